/* File: verilog/i2cc_pkg.sv */
// constants and types for the two-wire bus controller
package i2cc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned BUS_FREE_NS   = 4700;
    localparam logic [7:0]  BUS_FREE_CYC  =
        8'((BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] LOW_TIME_RST  = 16'hFFFF;
    localparam logic [15:0] HIGH_TIME_RST = 16'hFFFF;
    localparam logic [14:0] HOLD_TIME_RST = 15'h3FFF;
    localparam logic [3:0]  LAST_BIT      = 4'h7;
    localparam logic [3:0]  ACK_SLOT      = 4'h8;
    // status word fields
    localparam int unsigned ST_ARB_LOST   = 0;
    localparam int unsigned ST_NACK       = 1;
    localparam int unsigned ST_STOP       = 2;
    localparam int unsigned ST_BUSY       = 3;
    localparam int unsigned ST_MASTER     = 4;
    localparam int unsigned ST_XMIT       = 5;
    localparam int unsigned ST_ADDRESSED  = 6;
    localparam int unsigned ST_FLAG       = 10;
    typedef enum logic [7:0] {
        M_IDLE  = 8'h01,
        M_START = 8'h02,
        M_LOW   = 8'h04,
        M_HIGH  = 8'h08,
        M_STOPA = 8'h10,
        M_STOPB = 8'h20,
        M_RSA   = 8'h40,
        M_RSB   = 8'h80
    } i2cc_mstate_t;
endpackage

/* File: verilog/i2cc_ctrl.sv */
// two-wire bus controller, master and slave, with receive buffer
`timescale 1ns/1ps
`default_nettype none
module i2cc_ctrl (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        start_req,
    input  wire logic        stop_req,
    input  wire logic        restart_req,
    input  wire logic        ack_send_enable,
    input  wire logic [6:0]  own_addr,
    input  wire logic        cfg_wr,
    input  wire logic [15:0] low_time_wdata,
    input  wire logic [15:0] high_time_wdata,
    input  wire logic [14:0] hold_time_wdata,
    input  wire logic        status_wr,
    input  wire logic [15:0] status_wdata,
    output logic [15:0]      bus_status_reg,
    output logic             bus_event_flag,
    output logic             bus_busy,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    input  wire logic        rx_ready
);
    import i2cc_pkg::*;

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    logic         scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    logic         scl_rise, scl_fall, start_det, stop_det;
    logic [15:0]  clock_low_time_q, clock_high_time_q;
    logic [14:0]  data_hold_time_q;
    i2cc_mstate_t mst_q;
    logic         master_q;
    logic [15:0]  gcnt_q;
    logic [3:0]   bit_cnt_q;
    logic [7:0]   shreg_q;
    logic         is_addr_q, xmit_q, active_q, addressed_q, ack_rx_q, need_tx_q;
    logic [15:0]  hcnt_q;
    logic         hrun_q, sda_eng_q;
    logic         busy_q, free_run_q;
    logic [7:0]   free_cnt_q;
    logic         flag_q, lost_q, nack_q, stop_seen_q;
    logic [7:0]   head_q, tail_q;
    logic         head_v_q, tail_v_q;
    logic         launch, rs_go, byte_done, arb_loss, drv_bit, nack_ev, stop_ev, event_ev;
    logic         rx_full, rx_stall, hold_scl, take, push, pop, flag_clr, eng_bit;
    logic         sda_pull, scl_pull;
    logic [15:0]  wclr, status_d;

    // two-stage synchronisers, third stage for edges
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    assign scl_rise  = scl_s_q & ~scl_p_q;
    assign scl_fall  = ~scl_s_q & scl_p_q;
    assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clock_low_time_q  <= LOW_TIME_RST;
            clock_high_time_q <= HIGH_TIME_RST;
            data_hold_time_q  <= HOLD_TIME_RST;
        end else if (cfg_wr) begin
            clock_low_time_q  <= low_time_wdata;
            clock_high_time_q <= high_time_wdata;
            data_hold_time_q  <= hold_time_wdata;
        end
    end

    // bus stays busy for the free time after a STOP
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy_q     <= 1'b0;
            free_run_q <= 1'b0;
            free_cnt_q <= 8'h00;
        end else if (start_det) begin
            busy_q     <= 1'b1;
            free_run_q <= 1'b0;
        end else if (stop_det) begin
            free_run_q <= 1'b1;
            free_cnt_q <= 8'h00;
        end else if (free_run_q) begin
            free_cnt_q <= free_cnt_q + 8'h01;
            if (free_cnt_q == BUS_FREE_CYC - 8'h01) begin
                busy_q     <= 1'b0;
                free_run_q <= 1'b0;
            end
        end
    end

    assign rx_full   = head_v_q & tail_v_q;
    assign rx_stall  = active_q & ~xmit_q & ~is_addr_q & (bit_cnt_q == ACK_SLOT) & rx_full;
    assign hold_scl  = flag_q | need_tx_q | rx_stall;
    assign launch    = (mst_q == M_IDLE) & start_req & ~busy_q & ~flag_q;
    assign rs_go     = (mst_q == M_LOW) & (gcnt_q >= clock_low_time_q) & ~hold_scl
                       & ~stop_req & restart_req & (bit_cnt_q == 4'h0);
    assign byte_done = active_q & scl_fall & (bit_cnt_q == ACK_SLOT);
    assign drv_bit   = (bit_cnt_q == ACK_SLOT) ? ~xmit_q : xmit_q;
    // only bit slots count, not the SDA level a STOP or START forces
    assign arb_loss  = master_q & (mst_q == M_HIGH) & scl_rise & sda_eng_q & drv_bit
                       & ~sda_s_q;
    assign nack_ev   = byte_done & ack_rx_q & xmit_q;
    assign stop_ev   = stop_det & (active_q | master_q);
    assign event_ev  = byte_done | arb_loss | stop_ev;
    // a byte moves only on an edge where ready is shown
    assign take      = tx_ready & tx_valid;
    assign push      = active_q & scl_rise & (bit_cnt_q == ACK_SLOT) & ~xmit_q & ~is_addr_q;
    assign pop       = head_v_q & rx_ready;
    assign wclr      = status_wr ? ~status_wdata : 16'h0000;
    assign flag_clr  = flag_q & wclr[ST_FLAG];

    // master clock generator
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mst_q    <= M_IDLE;
            master_q <= 1'b0;
            gcnt_q   <= 16'h0000;
        end else if (arb_loss) begin
            mst_q    <= M_IDLE;
            master_q <= 1'b0;
            gcnt_q   <= 16'h0000;
        end else begin
            gcnt_q <= sat_inc(gcnt_q);
            unique case (mst_q)
                M_IDLE: begin
                    gcnt_q <= 16'h0000;
                    if (launch) begin
                        master_q <= 1'b1;
                        mst_q    <= M_START;
                    end
                end
                M_START: begin
                    if (need_tx_q) begin
                        gcnt_q <= 16'h0000;
                    end else if (gcnt_q >= clock_high_time_q) begin
                        mst_q  <= M_LOW;
                        gcnt_q <= 16'h0000;
                    end
                end
                M_LOW: begin
                    if (gcnt_q >= clock_low_time_q && !hold_scl) begin
                        gcnt_q <= 16'h0000;
                        if (stop_req) begin
                            mst_q <= M_STOPA;
                        end else if (rs_go) begin
                            mst_q <= M_RSA;
                        end else begin
                            mst_q <= M_HIGH;
                        end
                    end
                end
                M_HIGH: begin
                    if (scl_fall) begin
                        mst_q  <= M_LOW;
                        gcnt_q <= 16'h0000;
                    end else if (!scl_s_q) begin
                        gcnt_q <= 16'h0000;
                    end else if (gcnt_q >= clock_high_time_q) begin
                        mst_q  <= M_LOW;
                        gcnt_q <= 16'h0000;
                    end
                end
                M_STOPA: begin
                    if (gcnt_q >= {1'b0, data_hold_time_q}) begin
                        mst_q  <= M_STOPB;
                        gcnt_q <= 16'h0000;
                    end
                end
                M_STOPB: begin
                    if (!scl_s_q) begin
                        gcnt_q <= 16'h0000;
                    end else if (gcnt_q >= clock_high_time_q) begin
                        mst_q    <= M_IDLE;
                        master_q <= 1'b0;
                    end
                end
                M_RSA: begin
                    if (gcnt_q >= clock_low_time_q) begin
                        mst_q  <= M_RSB;
                        gcnt_q <= 16'h0000;
                    end
                end
                M_RSB: begin
                    if (!scl_s_q) begin
                        gcnt_q <= 16'h0000;
                    end else if (gcnt_q >= clock_high_time_q) begin
                        mst_q  <= M_START;
                        gcnt_q <= 16'h0000;
                    end
                end
            endcase
        end
    end

    // byte engine, shared by master and slave roles
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bit_cnt_q   <= 4'h0;
            shreg_q     <= 8'h00;
            is_addr_q   <= 1'b0;
            xmit_q      <= 1'b0;
            active_q    <= 1'b0;
            addressed_q <= 1'b0;
            ack_rx_q    <= 1'b1;
            need_tx_q   <= 1'b0;
        end else begin
            if (start_det) begin
                // first SCL fall after a START wraps this to bit 0
                bit_cnt_q   <= 4'hF;
                is_addr_q   <= 1'b1;
                active_q    <= 1'b1;
                xmit_q      <= master_q;
                addressed_q <= 1'b0;
            end else if (stop_det) begin
                bit_cnt_q <= 4'h0;
                active_q  <= 1'b0;
                xmit_q    <= 1'b0;
            end else begin
                if (arb_loss) begin
                    xmit_q <= 1'b0;
                    if (!is_addr_q) begin
                        active_q <= 1'b0;
                    end
                end
                if (active_q && scl_rise) begin
                    if (bit_cnt_q != ACK_SLOT) begin
                        shreg_q <= {shreg_q[6:0], sda_s_q};
                    end else begin
                        ack_rx_q <= sda_s_q;
                    end
                end
                if (byte_done) begin
                    bit_cnt_q <= 4'h0;
                    is_addr_q <= 1'b0;
                    if (is_addr_q && !master_q) begin
                        active_q <= addressed_q;
                        xmit_q   <= shreg_q[0];
                    end else if (is_addr_q) begin
                        xmit_q <= ~shreg_q[0];
                    end
                    if (ack_rx_q && xmit_q && !master_q) begin
                        active_q <= 1'b0;
                    end
                end else if (active_q && scl_fall) begin
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                    if (is_addr_q && !master_q && bit_cnt_q == LAST_BIT) begin
                        addressed_q <= (shreg_q[7:1] == own_addr);
                    end
                end
            end
            if (launch || rs_go) begin
                need_tx_q <= 1'b1;
            end else if (flag_clr && active_q && xmit_q && !is_addr_q
                         && !(master_q && (stop_req || restart_req))) begin
                need_tx_q <= 1'b1;
            end else if (take) begin
                shreg_q   <= tx_data;
                need_tx_q <= 1'b0;
            end
        end
    end

    always_comb begin
        eng_bit = 1'b1;
        if (!active_q) begin
            eng_bit = 1'b1;
        end else if (bit_cnt_q != ACK_SLOT) begin
            eng_bit = xmit_q ? shreg_q[7] : 1'b1;
        end else if (xmit_q) begin
            eng_bit = 1'b1;
        end else if (is_addr_q) begin
            eng_bit = ~addressed_q;
        end else begin
            eng_bit = ~ack_send_enable;
        end
    end

    // data level changes one hold time after SCL falls
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hcnt_q    <= 16'h0000;
            hrun_q    <= 1'b0;
            sda_eng_q <= 1'b1;
        end else if (arb_loss || start_det || stop_det || mst_q == M_STOPB) begin
            // master keeps SDA low from its START to the first bit
            hrun_q    <= 1'b0;
            sda_eng_q <= ~(start_det & master_q);
        end else if (scl_fall) begin
            hcnt_q <= 16'h0000;
            hrun_q <= 1'b1;
        end else if (hrun_q && hcnt_q >= {1'b0, data_hold_time_q}) begin
            hrun_q    <= 1'b0;
            sda_eng_q <= eng_bit;
        end else if (take && active_q && !hrun_q) begin
            sda_eng_q <= tx_data[7];
        end else begin
            hcnt_q <= sat_inc(hcnt_q);
        end
    end

    always_comb begin
        sda_pull = ~sda_eng_q;
        scl_pull = active_q & ~master_q & ~is_addr_q & hold_scl;
        if (master_q) begin
            if (mst_q == M_START) begin
                sda_pull = ~need_tx_q;
            end else if (mst_q == M_STOPA || mst_q == M_STOPB) begin
                sda_pull = 1'b1;
            end else if (mst_q == M_RSA || mst_q == M_RSB) begin
                sda_pull = 1'b0;
            end
            scl_pull = (mst_q == M_LOW) || (mst_q == M_STOPA) || (mst_q == M_RSA);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
            sda_o  <= 1'b1;
            scl_oe <= 1'b0;
            scl_o  <= 1'b1;
        end else begin
            sda_oe <= sda_pull;
            sda_o  <= ~sda_pull;
            scl_oe <= scl_pull;
            scl_o  <= ~scl_pull;
        end
    end

    // sticky status; a set in the same cycle wins over a clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag_q      <= 1'b0;
            lost_q      <= 1'b0;
            nack_q      <= 1'b0;
            stop_seen_q <= 1'b0;
        end else begin
            flag_q      <= event_ev | (flag_q & ~wclr[ST_FLAG]);
            lost_q      <= arb_loss | (lost_q & ~wclr[ST_ARB_LOST]);
            nack_q      <= nack_ev | (nack_q & ~wclr[ST_NACK]);
            stop_seen_q <= stop_ev | (stop_seen_q & ~wclr[ST_STOP]);
        end
    end

    always_comb begin
        status_d               = 16'h0000;
        status_d[ST_ARB_LOST]  = lost_q;
        status_d[ST_NACK]      = nack_q;
        status_d[ST_STOP]      = stop_seen_q;
        status_d[ST_BUSY]      = busy_q;
        status_d[ST_MASTER]    = master_q;
        status_d[ST_XMIT]      = xmit_q;
        status_d[ST_ADDRESSED] = active_q & ~master_q & addressed_q;
        status_d[ST_FLAG]      = flag_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_status_reg <= 16'h0000;
            bus_event_flag <= 1'b0;
            bus_busy       <= 1'b0;
            tx_ready       <= 1'b0;
        end else begin
            bus_status_reg <= status_d;
            bus_event_flag <= event_ev | (flag_q & ~wclr[ST_FLAG]);
            bus_busy       <= busy_q;
            tx_ready       <= need_tx_q & ~take;
        end
    end

    // two-entry receive buffer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            head_q   <= 8'h00;
            tail_q   <= 8'h00;
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
        end else begin
            if (pop) begin
                head_q   <= tail_q;
                head_v_q <= tail_v_q;
                tail_v_q <= 1'b0;
            end
            if (push) begin
                if (!head_v_q || (pop && !tail_v_q)) begin
                    head_q   <= shreg_q;
                    head_v_q <= 1'b1;
                end else begin
                    tail_q   <= shreg_q;
                    tail_v_q <= 1'b1;
                end
            end
        end
    end

    assign rx_data  = head_q;
    assign rx_valid = head_v_q;

endmodule // i2cc_ctrl
`default_nettype wire

/* File: tb/i2cc_ctrl_properties.sv */
// concurrent checks on the two-wire bus controller ports
`timescale 1ns/1ps
`default_nettype none
module i2cc_ctrl_properties
    import i2cc_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        scl_o,
    input wire logic        sda_o,
    input wire logic        scl_oe,
    input wire logic        sda_oe,
    input wire logic        start_req,
    input wire logic        status_wr,
    input wire logic [15:0] status_wdata,
    input wire logic [15:0] bus_status_reg,
    input wire logic        bus_event_flag,
    input wire logic        bus_busy,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic        rx_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // cycles since a STOP appeared on the pins
    int stop_cnt;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) stop_cnt <= 1000;
        else if (scl_i && $rose(sda_i)) stop_cnt <= 0;
        else if (stop_cnt < 1000) stop_cnt <= stop_cnt + 1;
    end
    property p_flag_bit; bus_status_reg[ST_FLAG] == $past(bus_event_flag); endproperty
    a_flag_bit: assert property (p_flag_bit) else $error("flag bit lost");
    property p_hold_low; bus_event_flag && scl_oe && !status_wr |=> scl_oe; endproperty
    a_hold_low: assert property (p_hold_low) else $error("clock let go");
    property p_clear; status_wr && !status_wdata[ST_FLAG] |=> !bus_event_flag; endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_reset_idle;
        $rose(rst_n) |-> !scl_oe && !sda_oe && bus_status_reg == 16'h0000 && !rx_valid;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle");
    property p_start_free; $rose(sda_oe) && scl_i && !bus_busy |-> $past(start_req); endproperty
    a_start_free: assert property (p_start_free) else $error("unasked start");
    property p_busy_on_start; scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] bus_busy; endproperty
    a_busy_on_start: assert property (p_busy_on_start) else $error("no busy");
    property p_free_time; $fell(bus_busy) |-> stop_cnt >= 90; endproperty
    a_free_time: assert property (p_free_time) else $error("free too soon");
    property p_tx_drop; tx_ready && tx_valid |-> ##[1:2] !tx_ready; endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("ready stuck");
    property p_open_drain; scl_o == !scl_oe && sda_o == !sda_oe; endproperty
    a_open_drain: assert property (p_open_drain) else $error("drives high");
endmodule // i2cc_ctrl_properties
`default_nettype wire

/* File: tb/i2cc_slave_model.sv */
// behavioural slave on the two-wire bus, write transfers only
`timescale 1ns/1ps
`default_nettype none
module i2cc_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_oe,
    output logic [7:0]      last_byte
);
    logic [7:0] sh;
    int         cnt;
    logic       act;
    logic       adr;
    initial begin
        sda_oe = 1'b0;
        last_byte = 8'h00;
        sh = 8'h00;
        cnt = 0;
        act = 1'b0;
        adr = 1'b0;
    end
    always @(negedge sda) if (scl) begin
        cnt = 0;
        act = 1'b1;
        adr = 1'b1;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) if (act && cnt < 8) begin
        sh = {sh[6:0], sda};
        cnt++;
    end
    // never stretches the clock, so the master never waits
    always @(negedge scl) if (act) begin
        if (cnt == 8) begin
            if (!adr) last_byte = sh;
            act = !adr || sh[7:1] == ADDR;
            sda_oe = act;
            adr = 1'b0;
            cnt = 9;
        end else if (cnt == 9) begin
            sda_oe = 1'b0;
            cnt = 0;
        end
    end
endmodule // i2cc_slave_model
`default_nettype wire

/* File: tb/test_i2cc_ctrl.sv */
// self-checking bench for the two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
module test_i2cc_ctrl;
    import i2cc_pkg::*;
    logic        ref_clk = 1'b0, rst_n = 1'b0, start_req = 1'b0, stop_req = 1'b0;
    logic        cfg_wr = 1'b0, status_wr = 1'b0, tx_valid = 1'b0;
    logic [15:0] status_wdata = 16'h0000, cfg_val = 16'h0000, bus_status_reg;
    logic [7:0]  tx_data = 8'h00, m_byte;
    logic        scl_oe, sda_oe, m_sda_oe, tx_ready, bus_event_flag, bus_busy, rx_valid;
    logic [14:0] hold_val = 15'h0000;
    wire logic   scl = ~scl_oe;
    wire logic   sda = ~(sda_oe | m_sda_oe);
    int          n_errors = 0, n_tests = 0;
    always #25 ref_clk = ~ref_clk;
    i2cc_ctrl DUT (.ref_clk, .rst_n, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(),
        .sda_oe, .start_req, .stop_req, .restart_req(1'b0), .ack_send_enable(1'b1),
        .own_addr(7'h11), .cfg_wr, .low_time_wdata(cfg_val), .high_time_wdata(cfg_val),
        .hold_time_wdata(hold_val), .status_wr, .status_wdata, .bus_status_reg,
        .bus_event_flag, .bus_busy, .tx_data, .tx_valid, .tx_ready, .rx_data(), .rx_valid,
        .rx_ready(1'b1));
    i2cc_slave_model #(.ADDR(7'h2A)) u_slave (.scl, .sda, .sda_oe(m_sda_oe), .last_byte(m_byte));
    task automatic results;
        $display("errors %0d, checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // sel 0: event flag, 1: busy, 2: tx ready
    task automatic wait_for(input int sel, input logic lvl);
        int i;
        i = 0;
        @(negedge ref_clk);
        while ((sel == 0 ? bus_event_flag : sel == 1 ? bus_busy : tx_ready) !== lvl && i < 3000) begin
            @(negedge ref_clk);
            i++;
        end
        if (i == 3000) begin
            n_errors++;
            $display("unexpected at %0t: wait %0d timed out", $time, sel);
        end
    endtask
    task automatic wr_status(input logic [15:0] v);
        @(posedge ref_clk);
        status_wr <= 1'b1;
        status_wdata <= v;
        @(posedge ref_clk);
        status_wr <= 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] b);
        @(posedge ref_clk);
        tx_data <= b;
        tx_valid <= 1'b1;
        wait_for(2, 1'b1);
        @(posedge ref_clk);
        tx_valid <= 1'b0;
    endtask
    // one master write: address, data byte if acknowledged, then STOP
    task automatic xfer(input logic [6:0] a, input logic nack);
        @(posedge ref_clk);
        start_req <= 1'b1;
        put_byte({a, 1'b0});
        wait_for(1, 1'b1);
        @(posedge ref_clk);
        start_req <= 1'b0;
        wait_for(0, 1'b1);
        tick(2);
        chk(8'(bus_status_reg[ST_NACK]), 8'(nack));
        chk(8'(bus_status_reg[ST_MASTER]), 8'h01);
        tick(20);
        chk(8'(scl), 8'h00);
        if (!nack) begin
            wr_status(16'h0000);
            put_byte(8'hA5);
            wait_for(0, 1'b1);
            chk(m_byte, 8'hA5);
        end
        @(posedge ref_clk);
        stop_req <= 1'b1;
        wr_status(16'h0000);
        wait_for(0, 1'b1);
        tick(2);
        chk(8'(bus_status_reg[ST_STOP]), 8'h01);
        chk(8'({scl, sda, bus_busy}), 8'h07);
        chk(8'(rx_valid), 8'h00);
        stop_req <= 1'b0;
        wr_status(16'h0000);
        wait_for(1, 1'b0);
    endtask
    initial begin
        tick(16);
        rst_n <= 1'b1;
        tick(1);
        chk(8'({scl, sda, bus_busy}), 8'h06);
        chk(bus_status_reg[7:0], 8'h00);
        cfg_wr <= 1'b1;
        // low time must outlast sync delay plus hold, so data moves only while SCL low
        cfg_val <= 16'h0008;
        hold_val <= 15'h0001;
        tick(1);
        cfg_wr <= 1'b0;
        xfer(7'h2A, 1'b0);
        xfer(7'h33, 1'b1);
        results;
    end
    initial begin
        tick(40000);
        n_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        results;
    end
endmodule // test_i2cc_ctrl
bind i2cc_ctrl i2cc_ctrl_properties u_props (.ref_clk, .rst_n, .scl_i, .sda_i, .scl_o, .sda_o,
    .scl_oe, .sda_oe, .start_req, .status_wr, .status_wdata, .bus_status_reg, .bus_event_flag,
    .bus_busy, .tx_valid, .tx_ready, .rx_valid);
`default_nettype wire
